// File: src/rtcr_cfg.svh
`ifndef RTCR_CFG_SVH
`define RTCR_CFG_SVH

// Register byte offsets on the plain register port.
`define RTCR_ADDR_W       5
`define RTCR_OFF_CTL      5'h00
`define RTCR_OFF_CLR      5'h04
`define RTCR_OFF_SET      5'h08
`define RTCR_OFF_INV      5'h0C
`define RTCR_OFF_TIME     5'h10

// Control register bit positions.
`define RTCR_B_ON         15
`define RTCR_B_IDLE_STOP  13
`define RTCR_B_CLKSEL     9
`define RTCR_B_OUTSEL     7
`define RTCR_B_RUN        6
`define RTCR_B_WREN       3
`define RTCR_B_SYNC       2
`define RTCR_B_HALF       1
`define RTCR_B_OE         0
`define RTCR_B_TRIM       16
`define RTCR_TRIM_W       10

// Writable bits of the control register, and the optional fields.
`define RTCR_WMASK        32'h03FF_A789
`define RTCR_CLKSEL_M     32'h0000_0600
`define RTCR_OUTSEL1_M    32'h0000_0100
`define RTCR_OUTSEL0_M    32'h0000_0080
`define RTCR_RST_CTL      32'h0000_0000

// Seconds field of the time value register, in BCD.
`define RTCR_B_SEC        8
`define RTCR_SEC_W        7
`define RTCR_SEC_MAX      7'h59
`define RTCR_SEC_RST      7'h00

// Tick prescaler: 32768 ticks a second, ripple window of 32 ticks.
`define RTCR_PRE_W        15
`define RTCR_PRE_LAST     15'h7FFF
`define RTCR_RIPPLE_SH    5
`define RTCR_TO_W         16

// Tick source and pin source codes.
`define RTCR_SRC_LOWOSC   2'h0
`define RTCR_SRC_XTAL     2'h1
`define RTCR_OUT_ALARM    2'h0
`define RTCR_OUT_SECS     2'h1
`define RTCR_OUT_TICK     2'h2

`endif

// File: src/rtcr_pkg.sv
`include "rtcr_cfg.svh"

package rtcr_pkg;

  typedef struct packed {
    logic [31:0]              ctl;
    logic [`RTCR_SEC_W-1:0]   secs;
    logic [`RTCR_PRE_W-1:0]   pre;
    logic [`RTCR_TRIM_W-1:0]  hold;
    logic [`RTCR_TO_W-1:0]    idle_cnt;
    logic                     run;
    logic                     tick_prev;
    logic [31:0]              rdata;
    logic                     pin;
    logic                     drive_n;
    logic                     sec_wr;
    logic                     gated;
  } rtcr_state_t;

endpackage

// File: src/rtcr_ctrl.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`include "rtcr_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Ten-bit signed trim in 25:16; positive N adds N ticks per minute.
// - Negative trim removes ticks each minute; most negative removes 512.
// - Bit 15 enables the clock module; clear disables it.
// - Writes to the enable bit take effect only while unlocked.
// - Idle-stop bit 13 gates bus access while the processor idles.
// - Tick source 01 is crystal, 00 internal oscillator, others reserved.
// - Pin select 10 tick, 01 seconds clock, 00 alarm, 11 reserved.
// - Single select bit 7: 1 seconds clock, 0 alarm pulse.
// - Bit 6 reads 1 while the tick clock really runs.
// - Value registers are writable only while unlock bit 3 is set.
// - Unlock bit sets only during the system unlock sequence.
// - Bit 2 flags the window where a rollover ripple may occur.
// - Bit 1 is 0 in first half second, 1 in second half.
// - A seconds write clears the half-second flag.
// - Pin drive enable is output enable AND module enable.
// - Unimplemented control bits read zero and ignore writes.
// - Absent optional fields read zero and ignore writes.
// - Time value register accepts writes only while unlocked.
// - Clear, set and invert aliases at 0x4, 0x8, 0xC.
module rtcr_ctrl #(
  parameter int unsigned TICK_TIMEOUT = 12207,
  parameter bit          HAS_CLKSEL   = 1'b1,
  parameter int unsigned OUT_SEL_BITS = 2
) (
  input  logic                     clk_i,
  input  logic                     srst_i,
  input  logic [`RTCR_ADDR_W-1:0]  addr_i,
  input  logic [31:0]              wdata_i,
  input  logic                     wr_i,
  input  logic                     rd_i,
  output logic [31:0]              rdata_o,
  input  logic                     unlock_seq_i,
  input  logic                     cpu_idle_i,
  input  logic                     tick_xtal_i,
  input  logic                     tick_lowosc_i,
  input  logic                     alarm_pulse_i,
  output logic                     pin_o,
  output logic                     pin_drive_n_o,
  output logic                     value_write_unlock_o,
  output logic                     seconds_write_o,
  output logic                     bus_clk_gated_o
);

  ////////////////////////////////////////////////////////////////////////////

  // Applies a direct, clear, set or invert write to the current value.
  function automatic logic [31:0] alias_apply(
    input logic [`RTCR_ADDR_W-1:0] a,
    input logic [31:0]             cur,
    input logic [31:0]             w
  );
    logic [31:0] r;
    r = cur;
    case (a)
      `RTCR_OFF_CTL: r = w;
      `RTCR_OFF_CLR: r = cur & ~w;
      `RTCR_OFF_SET: r = cur | w;
      `RTCR_OFF_INV: r = cur ^ w;
      default:       r = cur;
    endcase
    return r;
  endfunction

  function automatic logic is_ctl(input logic [`RTCR_ADDR_W-1:0] a);
    return (a == `RTCR_OFF_CTL) || (a == `RTCR_OFF_CLR) ||
           (a == `RTCR_OFF_SET) || (a == `RTCR_OFF_INV);
  endfunction

  localparam logic [31:0] WMASK = `RTCR_WMASK
    & (HAS_CLKSEL ? 32'hFFFF_FFFF : ~`RTCR_CLKSEL_M)
    & ((OUT_SEL_BITS >= 2) ? 32'hFFFF_FFFF : ~`RTCR_OUTSEL1_M)
    & ((OUT_SEL_BITS >= 1) ? 32'hFFFF_FFFF : ~`RTCR_OUTSEL0_M);
  localparam logic [`RTCR_TO_W-1:0] TIMEOUT = `RTCR_TO_W'(TICK_TIMEOUT);

  rtcr_pkg::rtcr_state_t q;
  rtcr_pkg::rtcr_state_t d;

  logic                    on;
  logic                    wren;
  logic [1:0]              src;
  logic [1:0]              outsel;
  logic                    tick_lvl;
  logic                    tick_edge;
  logic                    sec_roll;
  logic                    min_roll;
  logic                    ripple;
  logic                    half;
  logic [31:0]             ctl_new;
  logic [31:0]             status;
  logic [`RTCR_TRIM_W-1:0] trim;

  assign on     = q.ctl[`RTCR_B_ON];
  assign wren   = q.ctl[`RTCR_B_WREN];
  assign src    = q.ctl[`RTCR_B_CLKSEL+:2];
  assign outsel = q.ctl[`RTCR_B_OUTSEL+:2];
  assign trim   = q.ctl[`RTCR_B_TRIM+:`RTCR_TRIM_W];
  // Half-second flag and ripple window both come straight from the
  // prescaler, so they never disagree with the count software sees.
  assign half   = q.pre[`RTCR_PRE_W-1];
  assign ripple = &q.pre[`RTCR_PRE_W-1:`RTCR_RIPPLE_SH];

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    // Reserved source codes select no tick, so the clock stops.
    case (src)
      `RTCR_SRC_XTAL:   tick_lvl = tick_xtal_i;
      `RTCR_SRC_LOWOSC: tick_lvl = tick_lowosc_i;
      default:          tick_lvl = 1'b0;
    endcase
  end

  assign tick_edge = on && tick_lvl && !q.tick_prev;
  assign sec_roll  = tick_edge && (q.hold == '0) &&
                     (q.pre == `RTCR_PRE_LAST);
  assign min_roll  = sec_roll && (q.secs == `RTCR_SEC_MAX);
  assign status    = {25'h0, q.run, 3'h0, ripple, half, 1'b0};

  always_comb
  begin
    d           = q;
    d.sec_wr    = 1'b0;
    d.rdata     = '0;
    d.tick_prev = tick_lvl;
    d.gated     = q.ctl[`RTCR_B_IDLE_STOP] && cpu_idle_i;
    ctl_new     = q.ctl;

    // Tick running detector: any rising edge restarts the watchdog.
    if (!on)
    begin
      d.run      = 1'b0;
      d.idle_cnt = '0;
    end
    else if (tick_lvl && !q.tick_prev)
    begin
      d.run      = 1'b1;
      d.idle_cnt = '0;
    end
    else if (q.idle_cnt >= TIMEOUT)
    begin
      d.run = 1'b0;
    end
    else
    begin
      d.idle_cnt = q.idle_cnt + 1'b1;
    end

    // Prescaler. Removed ticks are swallowed by the hold counter first.
    if (tick_edge && (q.hold != '0))
    begin
      d.hold = q.hold - 1'b1;
    end
    else if (tick_edge)
    begin
      d.pre = q.pre + 1'b1;
      if (sec_roll)
      begin
        if (q.secs == `RTCR_SEC_MAX)
        begin
          d.secs = `RTCR_SEC_RST;
        end
        else if (q.secs[3:0] == 4'h9)
        begin
          d.secs = {q.secs[6:4] + 3'h1, 4'h0};
        end
        else
        begin
          d.secs = q.secs + 7'h01;
        end
      end
      if (min_roll && !trim[`RTCR_TRIM_W-1])
      begin
        // Starting the new second N ticks in adds N ticks.
        d.pre = `RTCR_PRE_W'(trim);
      end
      else if (min_roll)
      begin
        d.hold = -trim;
      end
    end

    // Register port; frozen while the bus clock is gated in idle.
    if (wr_i && !q.gated && is_ctl(addr_i))
    begin
      ctl_new = alias_apply(addr_i, q.ctl, wdata_i) & WMASK;
      if (!wren)
      begin
        ctl_new[`RTCR_B_ON] = q.ctl[`RTCR_B_ON];
      end
      if (!unlock_seq_i)
      begin
        // Clearing the unlock is always allowed, setting is not.
        ctl_new[`RTCR_B_WREN] = ctl_new[`RTCR_B_WREN] && wren;
      end
      d.ctl = ctl_new;
    end
    else if (wr_i && !q.gated && (addr_i == `RTCR_OFF_TIME) && wren)
    begin
      // Restarting the prescaler clears the half-second flag and lets a
      // tick source change settle on a clean second.
      d.secs   = wdata_i[`RTCR_B_SEC+:`RTCR_SEC_W];
      d.pre    = '0;
      d.hold   = '0;
      d.sec_wr = 1'b1;
    end

    if (rd_i && !q.gated && (addr_i == `RTCR_OFF_CTL))
    begin
      d.rdata = q.ctl | status;
    end
    else if (rd_i && !q.gated && (addr_i == `RTCR_OFF_TIME))
    begin
      d.rdata = {17'h0, q.secs, 8'h0};
    end

    // Pin source; a single select bit maps onto the same codes.
    case (OUT_SEL_BITS >= 2 ? outsel : {1'b0, outsel[0]})
      `RTCR_OUT_TICK:  d.pin = tick_lvl;
      `RTCR_OUT_SECS:  d.pin = half;
      `RTCR_OUT_ALARM: d.pin = alarm_pulse_i;
      default:         d.pin = 1'b0;
    endcase
    d.drive_n = !(q.ctl[`RTCR_B_OE] && on);
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      q         <= '0;
      q.ctl     <= `RTCR_RST_CTL;
      q.secs    <= `RTCR_SEC_RST;
      q.drive_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata_o              = q.rdata;
  assign pin_o                = q.pin;
  assign pin_drive_n_o        = q.drive_n;
  assign value_write_unlock_o = q.ctl[`RTCR_B_WREN];
  assign seconds_write_o      = q.sec_wr;
  assign bus_clk_gated_o      = q.gated;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_ctl_wr;
    wr_i && !q.gated && is_ctl(addr_i);
  endsequence

  a_on_locked: assert property (
    s_ctl_wr ##0 !wren |=> $stable(on))
    else $error("enable bit changed while locked");

  a_unlock_seq: assert property (
    $rose(value_write_unlock_o) |-> $past(unlock_seq_i))
    else $error("unlock set outside the unlock sequence");

  a_time_lock: assert property (
    wr_i && (addr_i == `RTCR_OFF_TIME) && !wren |=> !seconds_write_o)
    else $error("time written while locked");

  a_half_clear: assert property (
    seconds_write_o |-> !half ##1 !half)
    else $error("half-second flag not cleared by seconds write");

  a_drive_and: assert property (
    ##1 (pin_drive_n_o == !$past(q.ctl[`RTCR_B_OE] && on)))
    else $error("pin drive is not enable AND output enable");

  a_resv_zero: assert property (
    rd_i && !q.gated && addr_i == `RTCR_OFF_CTL |=>
      (rdata_o & ~(WMASK | 32'h0000_0046)) == 32'h0)
    else $error("unimplemented control bit read nonzero");

  a_trim_pos: assert property (
    min_roll && !trim[`RTCR_TRIM_W-1] && !wr_i |=>
      q.pre == `RTCR_PRE_W'($past(trim)))
    else $error("positive trim not applied");

  a_trim_neg: assert property (
    min_roll && trim[`RTCR_TRIM_W-1] && !wr_i |=>
      q.hold == -$past(trim))
    else $error("negative trim not applied");

  a_off_frozen: assert property (
    !on && !wr_i |=> $stable(q.pre) && $stable(q.secs))
    else $error("time advanced while disabled");

  a_set_alias: assert property (
    wr_i && !q.gated && addr_i == `RTCR_OFF_SET |=>
      ((q.ctl & $past(wdata_i) & WMASK & ~32'h0000_8008) ==
       ($past(wdata_i) & WMASK & ~32'h0000_8008)))
    else $error("set alias did not set bits");

endmodule // rtcr_ctrl

// File: tb/rtcr_ctrl_tb_top.sv
`include "rtcr_cfg.svh"

module rtcr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [4:0]  a;
    logic [31:0] w;
    logic        u;
    logic [31:0] e;
  } rtcr_row_t;

  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [4:0]  addr_i = 5'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic        unlock_seq_i = 1'b0;
  logic        cpu_idle_i = 1'b0;
  logic        tick_xtal_i = 1'b0;
  logic        tick_lowosc_i = 1'b0;
  logic        alarm_pulse_i = 1'b0;
  logic        pin_o;
  logic        pin_drive_n_o;
  logic        value_write_unlock_o;
  logic        seconds_write_o;
  logic        bus_clk_gated_o;
  logic        tick_run = 1'b0;
  logic        tick_hold = 1'b0;
  logic [31:0] rdata_v;
  logic        pin_v;
  logic [31:0] d;
  logic [31:0] t0;
  int          miscompares = 0;
  int          checks = 0;
  rtcr_row_t   rows [8];

  // Fields that the reduced variant leaves out of its control register.
  localparam logic [31:0] VAR_M = `RTCR_CLKSEL_M | `RTCR_OUTSEL1_M;

  always #2.5 clk_i = ~clk_i;

  // Free-running low-oscillator tick, one rising edge every two clocks;
  // when stopped the tick follows the level that the tests set.
  always @(posedge clk_i)
    tick_lowosc_i <= tick_run ? ~tick_lowosc_i : tick_hold;

  rtcr_ctrl #(.TICK_TIMEOUT(20)) u_rtcr_ctrl (
    .clk_i                (clk_i),
    .srst_i               (srst_i),
    .addr_i               (addr_i),
    .wdata_i              (wdata_i),
    .wr_i                 (wr_i),
    .rd_i                 (rd_i),
    .rdata_o              (rdata_o),
    .unlock_seq_i         (unlock_seq_i),
    .cpu_idle_i           (cpu_idle_i),
    .tick_xtal_i          (tick_xtal_i),
    .tick_lowosc_i        (tick_lowosc_i),
    .alarm_pulse_i        (alarm_pulse_i),
    .pin_o                (pin_o),
    .pin_drive_n_o        (pin_drive_n_o),
    .value_write_unlock_o (value_write_unlock_o),
    .seconds_write_o      (seconds_write_o),
    .bus_clk_gated_o      (bus_clk_gated_o)
  );

  // Variant without tick source select and with a single pin select bit.
  if (1)
  begin : g_var
    rtcr_ctrl #(
      .TICK_TIMEOUT (20),
      .HAS_CLKSEL   (1'b0),
      .OUT_SEL_BITS (1)
    ) u_rtcr_ctrl (
      .clk_i                (clk_i),
      .srst_i               (srst_i),
      .addr_i               (addr_i),
      .wdata_i              (wdata_i),
      .wr_i                 (wr_i),
      .rd_i                 (rd_i),
      .rdata_o              (rdata_v),
      .unlock_seq_i         (unlock_seq_i),
      .cpu_idle_i           (cpu_idle_i),
      .tick_xtal_i          (tick_xtal_i),
      .tick_lowosc_i        (tick_lowosc_i),
      .alarm_pulse_i        (alarm_pulse_i),
      .pin_o                (pin_v),
      .pin_drive_n_o        (),
      .value_write_unlock_o (),
      .seconds_write_o      (),
      .bus_clk_gated_o      ()
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] w, input logic u);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= w;
    unlock_seq_i <= u;
    @(posedge clk_i);
    wr_i <= 1'b0;
    unlock_seq_i <= 1'b0;
    #1;
  endtask

  // The data are taken in the single cycle that follows the strobe.
  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    r = rdata_o;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #750000;
    miscompares++;
    test_done();
  end

  initial
  begin
    rows[0] = '{`RTCR_OFF_SET, 32'h0000_0008, 1'b1, 32'h0000_0008};
    rows[1] = '{`RTCR_OFF_CTL, 32'hFFFF_FFFF, 1'b0, 32'h03FF_A789};
    rows[2] = '{`RTCR_OFF_CLR, 32'h0000_8000, 1'b0, 32'h03FF_2789};
    rows[3] = '{`RTCR_OFF_INV, 32'h03FF_0000, 1'b0, 32'h0000_2789};
    rows[4] = '{`RTCR_OFF_CTL, 32'h0000_0000, 1'b0, 32'h0000_0000};
    rows[5] = '{`RTCR_OFF_CTL, 32'h0000_8008, 1'b0, 32'h0000_0000};
    rows[6] = '{`RTCR_OFF_SET, 32'h0000_0008, 1'b1, 32'h0000_0008};
    rows[7] = '{`RTCR_OFF_SET, 32'h0000_8001, 1'b0, 32'h0000_8009};
    wait_clk(10);
    chk("rdata_rst", rdata_o, 32'h0);
    srst_i <= 1'b0;
    wait_clk(1);
    chk("drive_n_rst", pin_drive_n_o, 32'h1);
    chk("unlock_rst", value_write_unlock_o, 32'h0);
    chk("gated_rst", bus_clk_gated_o, 32'h0);
    rd(`RTCR_OFF_CTL, d);
    chk("ctl_rst", d, `RTCR_RST_CTL);
    $display("Test reset done");

    // Each row builds on the control value left by the row before it.
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w, rows[i].u);
      rd(`RTCR_OFF_CTL, d);
      chk("ctl_row", d, rows[i].e);
      chk("row_var", rdata_v, rows[i].e & ~VAR_M);
    end
    chk("unlock_out", value_write_unlock_o, 32'h1);
    $display("Test register rows done");

    wr(`RTCR_OFF_TIME, 32'hFFFF_12FF, 1'b0);
    chk("sec_write", seconds_write_o, 32'h1);
    rd(`RTCR_OFF_TIME, d);
    chk("time_rd", d, 32'h0000_1200);
    chk("sec_write_end", seconds_write_o, 32'h0);
    wait_clk(2);
    chk("drive_on_oe", pin_drive_n_o, 32'h0);
    $display("Test time and drive done");

    alarm_pulse_i <= 1'b1;
    wait_clk(3);
    chk("pin_alarm", pin_o, 32'h1);
    wr(`RTCR_OFF_SET, 32'h0000_0100, 1'b0);
    tick_hold <= 1'b1;
    wait_clk(3);
    chk("pin_tick_hi", pin_o, 32'h1);
    tick_hold <= 1'b0;
    wait_clk(3);
    chk("pin_tick_lo", pin_o, 32'h0);
    chk("pin_var", pin_v, 32'h1);
    $display("Test pin source done");

    tick_run <= 1'b1;
    wait_clk(10);
    rd(`RTCR_OFF_CTL, d);
    chk("run_lowosc", d[6], 32'h1);
    wr(`RTCR_OFF_SET, 32'h0000_0200, 1'b0);
    wait_clk(30);
    rd(`RTCR_OFF_CTL, d);
    chk("run_xtal_idle", d[6], 32'h0);
    wr(`RTCR_OFF_CLR, 32'h0000_0200, 1'b0);
    // Trim of plus five for the minute rollover below, and the pin moves
    // from the tick to the seconds clock.
    wr(`RTCR_OFF_INV, 32'h0005_0180, 1'b0);
    wr(`RTCR_OFF_TIME, 32'h0, 1'b0);
    $display("Test tick source done");

    // Half second falls at 16384 tick edges, the ripple window at 32736,
    // and the 32768th edge after seconds 59 rolls the minute over.
    wait_clk(16000);
    rd(`RTCR_OFF_CTL, d);
    chk("half_first", d[2:1], 32'h0);
    chk("pin_secs_lo", pin_o, 32'h0);
    wait_clk(16800);
    rd(`RTCR_OFF_CTL, d);
    chk("half_second", d[2:1], 32'h1);
    chk("pin_secs_hi", pin_o, 32'h1);
    wr(`RTCR_OFF_TIME, 32'h0000_5900, 1'b0);
    rd(`RTCR_OFF_CTL, d);
    chk("half_clear", d[1], 32'h0);
    wait_clk(65497);
    rd(`RTCR_OFF_CTL, d);
    chk("ripple", d[2:1], 32'h3);
    wait_clk(40);
    rd(`RTCR_OFF_TIME, d);
    chk("minute_roll", d, 32'h0);
    tick_run <= 1'b0;
    $display("Test prescaler flags done");

    wr(`RTCR_OFF_CLR, 32'h0000_8000, 1'b0);
    wait_clk(2);
    chk("drive_off", pin_drive_n_o, 32'h1);
    wr(`RTCR_OFF_SET, 32'h0000_2000, 1'b0);
    cpu_idle_i <= 1'b1;
    wait_clk(2);
    chk("gated", bus_clk_gated_o, 32'h1);
    wr(`RTCR_OFF_CTL, 32'h0, 1'b0);
    rd(`RTCR_OFF_CTL, d);
    chk("gated_rd", d, 32'h0);
    cpu_idle_i <= 1'b0;
    wait_clk(2);
    rd(`RTCR_OFF_CTL, d);
    chk("idle_kept", d[13], 32'h1);
    $display("Test idle stop done");

    rd(`RTCR_OFF_SET, d);
    chk("alias_rd", d, 32'h0);
    rd(5'h14, d);
    chk("unmapped_rd", d, 32'h0);
    wr(`RTCR_OFF_CLR, 32'h0000_0008, 1'b0);
    rd(`RTCR_OFF_TIME, t0);
    wr(`RTCR_OFF_TIME, 32'h0000_3400, 1'b0);
    chk("sec_write_lock", seconds_write_o, 32'h0);
    rd(`RTCR_OFF_TIME, d);
    chk("time_locked", d, t0);
    $display("Test lock done");
    test_done();
  end

endmodule // rtcr_ctrl_tb_top
